//--- src/fpp_programmer.sv
// Programmer sequencer for a 1024 x 8 fuse PROM
// Behaviour
// - Drive target address and hold it through the word's cycle.
// - Hold chip select high before and during programming pulses.
// - Keep outputs released below disable level before raising supply.
// - Raise supply to programming level with controlled rise time.
// - Wait settle delay after supply up, then pulse selected output.
// - Pulse further bits under raised supply, settle delay between pulses.
// - Lower supply one settle delay after the last pulse.
// - Verify with chip select low; programmed bits read zero.
// - Retry failing bits until 1.0 ms total pulse time, then reject.
// - Split total time into shorter pulses.
// - Repeat sequence for each word requested.
// - Always drive address and chip select actively.
`timescale 1ns/1ps
module fpp_programmer
  import fpp_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int PULSE_CYCLES  = PULSE_CYC,
  parameter int RISE_CYCLES   = RISE_CYC,
  parameter int MAX_PULSES    = PULSE_MAX
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Request
  input  wire logic                          start_i,
  input  wire logic [fpp_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [fpp_pkg::DATA_W-1:0]    data_i,
  output logic                               ready_o,
  output fpp_pkg::fpp_result_type            result_o,
  // PROM pins
  output fpp_pkg::fpp_pins_type              pins_o,
  output logic                               supply_high_o,
  output logic [fpp_pkg::DATA_W-1:0]         prog_pulse_o,
  input  wire logic [fpp_pkg::DATA_W-1:0]    prom_data_i
);
  import fpp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_RISE   = 3'b001,
    S_SETTLE = 3'b010,
    S_PULSE  = 3'b011,
    S_FALL   = 3'b100,
    S_VERIFY = 3'b101
  } fpp_state_type;

  localparam int CW = 4;

  fpp_state_type          state_q;
  logic [CNT_W-1:0]       tmr_q;
  logic [ADDR_W-1:0]      addr_q;
  logic [DATA_W-1:0]      want_q;
  logic [DATA_W-1:0]      todo_q;
  logic [2:0]             bit_q;
  logic                   cs_n_q;
  logic                   vhi_q;
  logic [DATA_W-1:0]      pulse_q;
  fpp_result_type         res_q;
  logic [DATA_W*CW-1:0]   acc;
  logic [DATA_W-1:0]      inc;
  logic [DATA_W-1:0]      fail;
  logic [DATA_W-1:0]      spent;
  logic                   tmr_done;
  logic                   acc_clr;
  logic [DATA_W-1:0]      retry;

  assign tmr_done = (tmr_q == '0);
  // Any bit that differs from the wanted byte counts against the word
  assign fail  = want_q ^ prom_data_i;
  // Only intact fuses can still be pulsed; a zero cannot become one
  assign retry = fail & ~want_q & ~spent;

  // Bits whose time budget is used up
  // Budget counts whole pulses, so its limit is total over pulse width
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_spent
      assign spent[g] = (acc[g*CW +: CW] >= CW'(MAX_PULSES));
    end
  endgenerate

  // One count per pulse ending on that bit
  assign inc = (state_q == S_PULSE && tmr_done) ? pulse_q : '0;
  assign acc_clr = (state_q == S_IDLE) && start_i;

  fpp_time_acc #(
    .DATA_W (DATA_W),
    .CW     (CW)
  ) u_acc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (acc_clr),
    .inc_i   (inc),
    .count_o (acc)
  );

  // Pick the lowest outstanding bit
  function automatic logic [2:0] first_bit(input logic [DATA_W-1:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      tmr_q   <= '0;
      addr_q  <= '0;
      want_q  <= BYTE_ERASED;
      todo_q  <= '0;
      bit_q   <= '0;
      cs_n_q  <= 1'b1;
      vhi_q   <= 1'b0;
      pulse_q <= '0;
    end else begin
      // One shared down-counter times every phase
      if (!tmr_done) begin
        tmr_q <= tmr_q - CNT_W'(1);
      end
      unique case (state_q)
        S_IDLE: begin
          if (start_i) begin
            addr_q  <= addr_i;
            want_q  <= data_i;
            todo_q  <= ~data_i;
            cs_n_q  <= 1'b1;
            pulse_q <= '0;
            // Supply starts its ramp on the taking edge
            vhi_q   <= 1'b1;
            tmr_q   <= CNT_W'(RISE_CYCLES);
            state_q <= (~data_i == '0) ? S_FALL : S_RISE;
            // Nothing to blow: skip the ramp, pass through fall with a zero count to verify
            if (~data_i == '0) begin
              vhi_q <= 1'b0;
              tmr_q <= '0;
            end
          end
        end
        S_RISE: begin
          if (tmr_done) begin
            tmr_q   <= CNT_W'(SETTLE_CYCLES);
            state_q <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (tmr_done) begin
            if (todo_q == '0) begin
              vhi_q   <= 1'b0;
              tmr_q   <= CNT_W'(RISE_CYCLES);
              state_q <= S_FALL;
            end else begin
              bit_q   <= first_bit(todo_q);
              pulse_q <= DATA_W'(1) << first_bit(todo_q);
              tmr_q   <= CNT_W'(PULSE_CYCLES);
              state_q <= S_PULSE;
            end
          end
        end
        S_PULSE: begin
          // Budget for this bit is charged as the pulse ends
          if (tmr_done) begin
            pulse_q <= '0;
            todo_q[bit_q] <= 1'b0;
            tmr_q   <= CNT_W'(SETTLE_CYCLES);
            state_q <= S_SETTLE;
          end
        end
        S_FALL: begin
          // Fall time reuses the rise count
          if (tmr_done) begin
            cs_n_q  <= 1'b0;
            tmr_q   <= CNT_W'(VERIFY_CYC);
            state_q <= S_VERIFY;
          end
        end
        S_VERIFY: begin
          if (tmr_done) begin
            cs_n_q <= 1'b1;
            // Blown bits wanted as one are reported, never retried
            if (retry != '0) begin
              todo_q  <= retry;
              vhi_q   <= 1'b1;
              tmr_q   <= CNT_W'(RISE_CYCLES);
              state_q <= S_RISE;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Outcome of each word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_q <= '0;
    end else begin
      res_q.done <= 1'b0;
      // Done pulses for one cycle; the other fields hold until the next word ends
      if (state_q == S_VERIFY && tmr_done && retry == '0) begin
        res_q.done      <= 1'b1;
        res_q.reject    <= (fail != '0);
        res_q.read_data <= prom_data_i;
        res_q.fail_bits <= fail;
      end
    end
  end

  assign ready_o       = (state_q == S_IDLE);
  assign result_o      = res_q;
  assign pins_o.addr   = addr_q;
  assign pins_o.cs_n   = cs_n_q;
  assign supply_high_o = vhi_q;
  assign prog_pulse_o  = pulse_q;

  // Checks
  cs_hi_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pulse_q != '0) |-> cs_n_q && vhi_q)
    else $error("pulse while selected or supply low");
  one_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(pulse_q))
    else $error("more than one output pulsed");
  addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q != S_IDLE && $past(state_q) != S_IDLE) |-> $stable(addr_q))
    else $error("address changed mid word");
  pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pulse_q != '0) |-> (pulse_q != '0)[*8])
    else $error("pulse too short");
  gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(pulse_q != '0) |-> (pulse_q == '0)[*8])
    else $error("pulses too close");
  fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(pulse_q != '0) |-> vhi_q[*8])
    else $error("supply dropped before settle");
  verify_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cs_n_q |-> !vhi_q && pulse_q == '0)
    else $error("verify under programming supply");
  budget_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == S_SETTLE && tmr_done && todo_q != '0) |->
      !spent[first_bit(todo_q)])
    else $error("bit pulsed past its budget");
  supply_cs_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vhi_q |-> cs_n_q)
    else $error("supply raised while selected");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == S_IDLE) |-> !vhi_q && pulse_q == '0)
    else $error("idle with supply or pulse on");
  rise_supply_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == S_RISE) |-> vhi_q && pulse_q == '0)
    else $error("ramp without supply or with a pulse");
  first_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(vhi_q) |-> (pulse_q == '0)[*8])
    else $error("pulse too soon after supply rise");
  pulse_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pulse_q != '0) |-> $past(state_q) == S_SETTLE)
    else $error("pulse not preceded by a settle");
  fall_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == S_FALL) |-> !vhi_q && cs_n_q)
    else $error("supply high or selected while falling");
  verify_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(cs_n_q) |-> (!cs_n_q)[*2])
    else $error("verify window too short");
  good_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (res_q.done && !res_q.reject) |-> res_q.read_data == want_q)
    else $error("accepted word differs from request");
  blank_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pulse_q & want_q) == '0)
    else $error("pulse on a bit wanted as one");
  acc_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (inc & spent) == '0)
    else $error("pulse charged to a spent bit");
  addr_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ready_o && start_i) |=> addr_q == $past(addr_i))
    else $error("address not captured on start");

  // Main scenarios
  word_c: cover property (@(posedge clk_i) disable iff (rst_i)
    res_q.done && !res_q.reject);
  reject_c: cover property (@(posedge clk_i) disable iff (rst_i)
    res_q.done && res_q.reject);
  retry_c: cover property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_VERIFY ##1 state_q == S_RISE);
  blank_c: cover property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_IDLE && start_i && (&data_i));
  multi_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(pulse_q != '0) && todo_q != '0);
endmodule

//--- src/fpp_pkg.sv
// Shared constants and types for the fuse PROM programmer
package fpp_pkg;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int WORDS     = 1024;
  localparam int CLK_MHZ   = 20;
  // Times in microseconds
  localparam int T_RISE_US   = 1;
  localparam int T_SETTLE_US = 10;
  localparam int T_PULSE_US  = 100;
  localparam int T_TOTAL_US  = 1000;
  localparam int RISE_CYC   = T_RISE_US * CLK_MHZ;
  localparam int SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
  localparam int PULSE_CYC  = T_PULSE_US * CLK_MHZ;
  localparam int TOTAL_CYC  = T_TOTAL_US * CLK_MHZ;
  localparam int VERIFY_CYC = 2;
  localparam int CNT_W      = 16;
  localparam int PULSE_MAX  = TOTAL_CYC / PULSE_CYC;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cs_n;
  } fpp_pins_type;

  typedef struct packed {
    logic              done;
    logic              reject;
    logic [DATA_W-1:0] read_data;
    logic [DATA_W-1:0] fail_bits;
  } fpp_result_type;
endpackage

//--- src/fpp_time_acc.sv
// Per-bit accumulated pulse count memory
`timescale 1ns/1ps
module fpp_time_acc #(
  parameter int DATA_W = 8,
  parameter int CW     = 4
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              clear_i,
  input  wire logic [DATA_W-1:0] inc_i,
  // Totals
  output logic [DATA_W*CW-1:0]   count_o
);
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_bit
      logic [CW-1:0] cnt_q;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_q <= '0;
        end else if (clear_i) begin
          cnt_q <= '0;
        end else if (inc_i[g]) begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
      assign count_o[g*CW +: CW] = cnt_q;
    end
  endgenerate
endmodule

//--- test/fpp_prom_model.sv
// Behavioural 1024 x 8 fuse PROM that also counts programming faults
`timescale 1ns/1ps
module fpp_prom_model
  import fpp_pkg::*;
#(
  parameter int PULSE_MIN = 10,
  parameter int GAP_MIN   = 10
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // Pins from the programmer
  input  fpp_pkg::fpp_pins_type pins_i,
  input  wire logic            supply_high_i,
  input  wire logic [7:0]      pulse_i,
  // Fuses that never blow, or need two pulses
  input  wire logic [7:0]      hard_i,
  input  wire logic [7:0]      slow_i,
  // Read back and fault count
  output logic [7:0]           data_o,
  output logic [7:0]           viol_o
);
  logic [7:0] mem [WORDS];
  logic [7:0] last_q = 8'h00;
  logic [7:0] prev_q;
  logic [7:0] hit_q;
  logic [9:0] addr_q;
  logic       sup_q;
  int         wid_q;
  int         idle_q;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Released outputs toggle so a stale value never passes for a read
  assign data_o = (!pins_i.cs_n && !supply_high_i) ? mem[pins_i.addr]
                                                   : ~last_q;
  always @(posedge clk_i) last_q <= data_o;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      viol_o <= 8'h00;
      prev_q <= 8'h00;
      hit_q  <= 8'h00;
      sup_q  <= 1'b0;
      wid_q  <= 0;
      idle_q <= 0;
    end else begin
      if ($isunknown(pins_i) || (pulse_i != 0 &&
          (!supply_high_i || pins_i.cs_n !== 1'b1)))
        viol_o <= viol_o + 8'h01;
      if (sup_q && pins_i.addr != addr_q)
        viol_o <= viol_o + 8'h01;
      if (pulse_i != 0 && prev_q == 0 && idle_q < GAP_MIN)
        viol_o <= viol_o + 8'h01;
      if (sup_q && !supply_high_i && idle_q < GAP_MIN)
        viol_o <= viol_o + 8'h01;
      if (pulse_i == 0 && prev_q != 0) begin
        if (wid_q < PULSE_MIN)
          viol_o <= viol_o + 8'h01;
        else
          for (int b = 0; b < 8; b++)
            if (prev_q[b] && !hard_i[b]) begin
              if (slow_i[b] && !hit_q[b]) hit_q[b] <= 1'b1;
              else mem[addr_q][b] <= 1'b0;
            end
      end
      wid_q  <= (pulse_i != 0) ? wid_q + 1 : 0;
      idle_q <= (pulse_i != 0 || !supply_high_i) ? 0 : idle_q + 1;
      prev_q <= pulse_i;
      sup_q  <= supply_high_i;
      addr_q <= pins_i.addr;
    end
  end
endmodule

//--- test/fpp_programmer_test.sv
// Self-checking bench for the fuse PROM programmer
`timescale 1ns/1ps
module fpp_programmer_test;
  import fpp_pkg::*;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           start_i = 1'b0;
  logic [9:0]     addr_i = 10'h000;
  logic [7:0]     data_i = 8'hFF;
  logic [7:0]     hard = 8'h00;
  logic [7:0]     slow = 8'h00;
  logic [7:0]     prom_data;
  logic [7:0]     viol;
  logic           ready_o;
  logic           supply_high_o;
  logic [7:0]     prog_pulse_o;
  logic [7:0]     prev_pulse = 8'h00;
  fpp_result_type result_o;
  fpp_result_type res;
  fpp_pins_type   pins_o;
  int             fail_count = 0;
  int             compares = 0;
  int             pulses = 0;
  fpp_programmer #(.SETTLE_CYCLES(10), .PULSE_CYCLES(10), .RISE_CYCLES(2),
    .MAX_PULSES(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
    .addr_i(addr_i), .data_i(data_i), .ready_o(ready_o),
    .result_o(result_o), .pins_o(pins_o), .supply_high_o(supply_high_o),
    .prog_pulse_o(prog_pulse_o), .prom_data_i(prom_data));
  fpp_prom_model prom (.clk_i(clk_i),
    .rst_i(rst_i), .pins_i(pins_o), .supply_high_i(supply_high_o),
    .pulse_i(prog_pulse_o), .hard_i(hard), .slow_i(slow),
    .data_o(prom_data), .viol_o(viol));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (prog_pulse_o != 0 && prev_pulse == 0) pulses++;
    prev_pulse <= prog_pulse_o;
  end
  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic prog(input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    addr_i = a;
    data_i = d;
    start_i = 1'b1;
    pulses = 0;
    @(negedge clk_i);
    start_i = 1'b0;
    n = 0;
    while (result_o.done !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    res = result_o;
    check(16'h0001, {15'h0, res.done});
  endtask
  task automatic t_reset;
    check(16'h0001, {15'h0, ready_o});
    check(16'h0001, {15'h0, pins_o.cs_n});
    check(16'h0000, {7'h0, supply_high_o, prog_pulse_o});
  endtask
  task automatic t_word;
    prog(10'h3FF, 8'hA5);
    check(16'h00A5, {8'h0, res.read_data});
    check(16'h0000, {7'h0, res.reject, res.fail_bits});
    check(16'h0004, pulses[15:0]);
  endtask
  task automatic t_blank;
    prog(10'h1FF, 8'hFF);
    check(16'h00FF, {8'h0, res.read_data});
    check(16'h0000, pulses[15:0]);
  endtask
  task automatic t_unblow;
    prog(10'h3FF, 8'hFF);
    check(16'h00A5, {8'h0, res.read_data});
    check(16'h015A, {7'h0, res.reject, res.fail_bits});
  endtask
  task automatic t_hard;
    hard = 8'h01;
    prog(10'h155, 8'hFE);
    hard = 8'h00;
    check(16'h0101, {7'h0, res.reject, res.fail_bits});
    check(16'h0003, pulses[15:0]);
  endtask
  task automatic t_slow;
    slow = 8'h80;
    prog(10'h2AA, 8'h7F);
    check(16'h007F, {8'h0, res.read_data});
    check(16'h0002, pulses[15:0]);
  endtask
  task automatic report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Longest word with retries is well under a thousand cycles
  initial begin
    #1_000_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    t_reset();
    rst_i = 1'b0;
    t_word();
    t_blank();
    t_unblow();
    t_hard();
    t_slow();
    check(16'h0000, {8'h0, viol});
    report_and_stop();
  end
endmodule
